// ==== include/fpc_pkg.sv ====
// Summary of operation
// - Unlock key register is write only and always reads as zero.
// - Key writes form an unlock sequence guarding flash program and erase.
// - Whole-array erase ignores the target address.
// - Page erase uses the target address to pick one page.
// - Row program uses the target address as the row to program.
// - Word program uses the target address as the word location.
// - Control and target address have clear, set, invert aliases at +4, +8, +c.
// - Reset clears all six registers to zero.
// - Unimplemented bits ignore writes and read as zero.
// - Target address is a full 32-bit read/write register.
package fpc_pkg;
    localparam logic [15:0] CTRL_OFS = 16'hf400;
    localparam logic [15:0] KEY_OFS = 16'hf410;
    localparam logic [15:0] ADDR_OFS = 16'hf420;
    localparam logic [15:0] DATA_OFS = 16'hf430;
    localparam logic [15:0] SRC_OFS = 16'hf440;
    localparam logic [15:0] IRQ_STAT_OFS = 16'hf450;
    localparam logic [15:0] IRQ_MASK_OFS = 16'hf460;
    localparam logic [3:0] ALIAS_CLR = 4'h4;
    localparam logic [3:0] ALIAS_SET = 4'h8;
    localparam logic [3:0] ALIAS_INV = 4'hc;
    localparam logic [31:0] RESET_VALUE = 32'h00000000;
    // Control register fields.
    localparam int START_BIT = 15;
    localparam int PERMIT_BIT = 14;
    localparam int FAULT_BIT = 13;
    localparam int LV_FAULT_BIT = 12;
    localparam int LV_STATE_BIT = 11;
    localparam logic [31:0] CTRL_SW_MASK = 32'h0000f00f;
    // Unlock key values; arbitrary values chosen for this block.
    localparam logic [31:0] KEY_FIRST = 32'h12345678;
    localparam logic [31:0] KEY_SECOND = 32'h87654321;
    // Operation codes.
    localparam logic [3:0] OP_NONE = 4'h0;
    localparam logic [3:0] OP_WORD = 4'h1;
    localparam logic [3:0] OP_ROW = 4'h3;
    localparam logic [3:0] OP_PAGE = 4'h4;
    localparam logic [3:0] OP_ARRAY = 4'h5;
    localparam logic [31:0] WORD_ALIGN = 32'hfffffffc;
    localparam logic [31:0] ROW_ALIGN = 32'hffffff80;
    localparam logic [31:0] PAGE_ALIGN = 32'hfffffc00;
    // Status events: bit 0 operation done, bit 1 fault.
    localparam logic [31:0] IRQ_BITS = 32'h00000003;
    typedef struct packed {
        logic [3:0] op;
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] src;
    } fpc_cmd_type;
    typedef enum logic [2:0] {
        LK_IDLE = 3'b001,
        LK_ONE = 3'b010,
        LK_OPEN = 3'b100
    } fpc_lock_type;
endpackage

// ==== rtl/fpc_regs.sv ====
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module fpc_regs (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [15:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output fpc_pkg::fpc_cmd_type cmd,
    output logic cmd_valid,
    input wire logic op_done,
    input wire logic op_fault,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_q, taddr_q, data_q, src_q, stat_q, mask_q;
    logic [31:0] ctrl_d, taddr_d;
    fpc_pkg::fpc_lock_type lock_q;
    logic busy_q, done_s, fault_s;
    logic [15:0] base;
    logic [3:0] sub;
    logic start_req;
    assign base = {addr[15:4], 4'h0};
    assign sub = addr[3:0];
    // Inputs from the flash array sit on other logic; synchronise anyway.
    logic [1:0] done_sy, fault_sy;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            done_sy <= 2'b00;
            fault_sy <= 2'b00;
        end else begin
            done_sy <= {done_sy[0], op_done};
            fault_sy <= {fault_sy[0], op_fault};
        end
    end
    assign done_s = done_sy[1] & busy_q;
    assign fault_s = fault_sy[1] & busy_q;

    ////////////////////////////////////////////////////////////////////////
    // Alias decode shared by control and target address.
    function automatic logic [31:0] alias_upd(input logic [31:0] cur, input logic [31:0] w,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = cur;
        case (s)
            4'h0: r = w;
            fpc_pkg::ALIAS_CLR: r = cur & ~w;
            fpc_pkg::ALIAS_SET: r = cur | w;
            fpc_pkg::ALIAS_INV: r = cur ^ w;
            default: r = cur;
        endcase
        return r;
    endfunction

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr && base == fpc_pkg::CTRL_OFS) begin
            // Hardware-owned bits are kept; only software bits take the alias update.
            ctrl_d = (alias_upd(ctrl_q, wdata, sub) & fpc_pkg::CTRL_SW_MASK)
                     | (ctrl_q & ~fpc_pkg::CTRL_SW_MASK);
        end
    end
    assign taddr_d = (wr && base == fpc_pkg::ADDR_OFS) ? alias_upd(taddr_q, wdata, sub) : taddr_q;

    // Start is only honoured from the open state and with the permit bit set.
    assign start_req = ctrl_d[fpc_pkg::START_BIT] & ~ctrl_q[fpc_pkg::START_BIT]
                       & ctrl_d[fpc_pkg::PERMIT_BIT] & (lock_q == fpc_pkg::LK_OPEN);

    // A first key word always restarts the sequence, so a repeated or abandoned attempt
    // never leaves the lock stuck closed for the next correct pair.
    logic key1_wr, key2_wr;
    assign key1_wr = wr && addr == fpc_pkg::KEY_OFS && wdata == fpc_pkg::KEY_FIRST;
    assign key2_wr = wr && addr == fpc_pkg::KEY_OFS && wdata == fpc_pkg::KEY_SECOND;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lock_q <= fpc_pkg::LK_IDLE;
        end else if (wr || rd) begin
            // Any access other than the expected next step closes the lock.
            case (lock_q)
                fpc_pkg::LK_IDLE: lock_q <= key1_wr ? fpc_pkg::LK_ONE : fpc_pkg::LK_IDLE;
                fpc_pkg::LK_ONE: lock_q <= key2_wr ? fpc_pkg::LK_OPEN
                    : (key1_wr ? fpc_pkg::LK_ONE : fpc_pkg::LK_IDLE);
                fpc_pkg::LK_OPEN: lock_q <= key1_wr ? fpc_pkg::LK_ONE : fpc_pkg::LK_IDLE;
                default: lock_q <= fpc_pkg::LK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= fpc_pkg::RESET_VALUE;
            busy_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            if (busy_q) begin
                ctrl_q[fpc_pkg::START_BIT] <= ~(done_s | fault_s);
            end else if (!start_req) begin
                ctrl_q[fpc_pkg::START_BIT] <= 1'b0;
            end
            if (fault_s) begin
                ctrl_q[fpc_pkg::FAULT_BIT] <= 1'b1;
            end
            ctrl_q[fpc_pkg::LV_STATE_BIT] <= 1'b0;
            if (start_req && !busy_q) begin
                busy_q <= 1'b1;
            end else if (done_s || fault_s) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            taddr_q <= fpc_pkg::RESET_VALUE;
            data_q <= fpc_pkg::RESET_VALUE;
            src_q <= fpc_pkg::RESET_VALUE;
        end else begin
            taddr_q <= taddr_d;
            if (wr && addr == fpc_pkg::DATA_OFS) begin
                data_q <= wdata;
            end
            if (wr && addr == fpc_pkg::SRC_OFS) begin
                src_q <= wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command issued to the array; the address is aligned to the operation.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cmd <= '0;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= start_req && !busy_q;
            if (start_req && !busy_q) begin
                cmd.op <= ctrl_d[3:0];
                cmd.data <= data_q;
                cmd.src <= src_q;
                case (ctrl_d[3:0])
                    fpc_pkg::OP_WORD: cmd.addr <= taddr_d & fpc_pkg::WORD_ALIGN;
                    fpc_pkg::OP_ROW: cmd.addr <= taddr_d & fpc_pkg::ROW_ALIGN;
                    fpc_pkg::OP_PAGE: cmd.addr <= taddr_d & fpc_pkg::PAGE_ALIGN;
                    fpc_pkg::OP_ARRAY: cmd.addr <= fpc_pkg::RESET_VALUE;
                    default: cmd.addr <= fpc_pkg::RESET_VALUE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status is read-to-clear; a new event in the read cycle still sets.
    logic rd_stat;
    assign rd_stat = rd && addr == fpc_pkg::IRQ_STAT_OFS;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stat_q <= fpc_pkg::RESET_VALUE;
            mask_q <= fpc_pkg::RESET_VALUE;
            irq <= 1'b0;
        end else begin
            stat_q <= ((rd_stat ? 32'h00000000 : stat_q) | {30'h0, fault_s, done_s})
                      & fpc_pkg::IRQ_BITS;
            if (wr && addr == fpc_pkg::IRQ_MASK_OFS) begin
                mask_q <= wdata & fpc_pkg::IRQ_BITS;
            end
            irq <= |(((rd_stat ? 32'h00000000 : stat_q) | {30'h0, fault_s, done_s}) & mask_q);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= fpc_pkg::RESET_VALUE;
        end else if (rd) begin
            case (base)
                fpc_pkg::CTRL_OFS: rdata <= ctrl_q & fpc_pkg::CTRL_SW_MASK
                    | (ctrl_q & (32'h1 << fpc_pkg::LV_STATE_BIT));
                fpc_pkg::KEY_OFS: rdata <= fpc_pkg::RESET_VALUE;
                fpc_pkg::ADDR_OFS: rdata <= taddr_q;
                fpc_pkg::DATA_OFS: rdata <= data_q;
                fpc_pkg::SRC_OFS: rdata <= src_q;
                fpc_pkg::IRQ_STAT_OFS: rdata <= stat_q;
                fpc_pkg::IRQ_MASK_OFS: rdata <= mask_q;
                default: rdata <= fpc_pkg::RESET_VALUE;
            endcase
        end else begin
            rdata <= fpc_pkg::RESET_VALUE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    key_reads_zero_a: assert property (@(posedge clock) disable iff (!nrst)
        rd && addr == fpc_pkg::KEY_OFS |=> rdata == 32'h0)
        else $error("Key register read not zero.");
    addr_readback_a: assert property (@(posedge clock) disable iff (!nrst)
        wr && addr == fpc_pkg::ADDR_OFS ##1 rd && addr == fpc_pkg::ADDR_OFS
        |=> rdata == $past(wdata, 2))
        else $error("Target address readback mismatch.");
    addr_set_a: assert property (@(posedge clock) disable iff (!nrst)
        wr && addr == fpc_pkg::ADDR_OFS + 16'h8 |=> taddr_q == ($past(taddr_q) | $past(wdata)))
        else $error("Set alias wrong.");
    addr_inv_a: assert property (@(posedge clock) disable iff (!nrst)
        wr && addr == fpc_pkg::ADDR_OFS + 16'hc |=> taddr_q == ($past(taddr_q) ^ $past(wdata)))
        else $error("Invert alias wrong.");
    sequence key_seq;
        wr && addr == fpc_pkg::KEY_OFS && wdata == fpc_pkg::KEY_FIRST
        ##1 wr && addr == fpc_pkg::KEY_OFS && wdata == fpc_pkg::KEY_SECOND;
    endsequence
    no_start_locked_a: assert property (@(posedge clock) disable iff (!nrst)
        cmd_valid |-> $past(lock_q) == fpc_pkg::LK_OPEN)
        else $error("Start without unlock.");
    unlock_opens_a: assert property (@(posedge clock) disable iff (!nrst)
        key_seq |=> lock_q == fpc_pkg::LK_OPEN)
        else $error("Key sequence did not unlock.");
    array_addr_a: assert property (@(posedge clock) disable iff (!nrst)
        cmd_valid && cmd.op == fpc_pkg::OP_ARRAY |-> cmd.addr == 32'h0)
        else $error("Array erase used address.");
    unmapped_zero_a: assert property (@(posedge clock) disable iff (!nrst)
        rd && addr == 16'hf470 |=> rdata == 32'h0)
        else $error("Unmapped read not zero.");
    irq_level_a: assert property (@(posedge clock) disable iff (!nrst)
        |(stat_q & mask_q) && !rd_stat |=> irq)
        else $error("Interrupt not raised.");
    addr_clr_a: assert property (@(posedge clock) disable iff (!nrst)
        wr && addr == fpc_pkg::ADDR_OFS + 16'(fpc_pkg::ALIAS_CLR)
        |=> taddr_q == ($past(taddr_q) & ~$past(wdata)))
        else $error("Clear alias wrong.");
    ctrl_unimpl_a: assert property (@(posedge clock) disable iff (!nrst)
        (ctrl_q & ~fpc_pkg::CTRL_SW_MASK) == 32'h00000000)
        else $error("Unimplemented control bit set.");
    locked_start_a: assert property (@(posedge clock) disable iff (!nrst)
        wr && addr == fpc_pkg::CTRL_OFS && wdata[fpc_pkg::START_BIT]
        && lock_q != fpc_pkg::LK_OPEN && !busy_q
        |=> !ctrl_q[fpc_pkg::START_BIT] && !cmd_valid)
        else $error("Locked start not refused.");
    // The start write must follow the key pair with no access in between.
    sequence start_write;
        wr && addr == fpc_pkg::CTRL_OFS && wdata[fpc_pkg::START_BIT]
        && wdata[fpc_pkg::PERMIT_BIT] && !busy_q;
    endsequence
    unlock_start_a: assert property (@(posedge clock) disable iff (!nrst)
        key_seq ##1 start_write |=> cmd_valid)
        else $error("Unlocked start ignored.");
    page_sel_a: assert property (@(posedge clock) disable iff (!nrst)
        cmd_valid && cmd.op == fpc_pkg::OP_PAGE |-> cmd.addr == ($past(taddr_d) & fpc_pkg::PAGE_ALIGN))
        else $error("Page address wrong.");
    row_sel_a: assert property (@(posedge clock) disable iff (!nrst)
        cmd_valid && cmd.op == fpc_pkg::OP_ROW |-> cmd.addr == ($past(taddr_d) & fpc_pkg::ROW_ALIGN))
        else $error("Row address wrong.");
    word_sel_a: assert property (@(posedge clock) disable iff (!nrst)
        cmd_valid && cmd.op == fpc_pkg::OP_WORD |-> cmd.addr == ($past(taddr_d) & fpc_pkg::WORD_ALIGN))
        else $error("Word address wrong.");
endmodule

// ==== test/fpc_regs_tb.sv ====
`timescale 1ns/1ps
module testbench;
    logic clock, nrst, wr, rd, op_done, op_fault, cmd_valid, irq, rd_d;
    logic [15:0] addr;
    logic [31:0] wdata, rdata, taddr;
    fpc_pkg::fpc_cmd_type cmd, ecmd;
    logic [31:0] exp_q[$];
    fpc_pkg::fpc_cmd_type cmd_q[$];
    int fails, num_checks;
    localparam logic [3:0] OPS [4] = '{fpc_pkg::OP_WORD, fpc_pkg::OP_ROW, fpc_pkg::OP_PAGE,
        fpc_pkg::OP_ARRAY};
    fpc_regs fpc_regs_inst (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .cmd(cmd), .cmd_valid(cmd_valid), .op_done(op_done),
        .op_fault(op_fault), .irq(irq));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always_ff @(posedge clock) rd_d <= rd;
    task automatic chk(input logic [99:0] got, input logic [99:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Reads are judged half a cycle after the edge that answers them, so the order in
    // which the simulator runs the edge processes cannot matter.
    always @(negedge clock) begin
        if (rd_d === 1'b1) begin
            if (exp_q.size() == 0) chk(1'b1, 1'b0);
            else chk(rdata, exp_q.pop_front());
        end
        if (cmd_valid !== 1'b0) begin
            if (cmd_q.size() == 0) chk(cmd_valid, 1'b0);
            else chk(cmd, cmd_q.pop_front());
        end
    end
    task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask
    task automatic wr_t(input logic [15:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd_t(input logic [15:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 32'h00000000);
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 16'h0000, 32'h00000000);
    endtask
    task automatic close_out;
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // One unlocked operation; the array answers with done or fault a few cycles on.
    task automatic run_op(input logic [3:0] op, input logic flt);
        taddr = $urandom();
        wr_t(fpc_pkg::ADDR_OFS, taddr);
        if (flt) wr_t(fpc_pkg::KEY_OFS, fpc_pkg::KEY_FIRST);
        wr_t(fpc_pkg::KEY_OFS, fpc_pkg::KEY_FIRST);
        wr_t(fpc_pkg::KEY_OFS, fpc_pkg::KEY_SECOND);
        ecmd.op = op;
        case (op)
            fpc_pkg::OP_WORD: ecmd.addr = taddr & fpc_pkg::WORD_ALIGN;
            fpc_pkg::OP_ROW: ecmd.addr = taddr & fpc_pkg::ROW_ALIGN;
            fpc_pkg::OP_PAGE: ecmd.addr = taddr & fpc_pkg::PAGE_ALIGN;
            default: ecmd.addr = 32'h00000000;
        endcase
        cmd_q.push_back(ecmd);
        wr_t(fpc_pkg::CTRL_OFS, {16'h0000, 4'hc, 8'h00, op});
        idle(3);
        op_done <= ~flt;
        op_fault <= flt;
        idle(1);
        op_done <= 1'b0;
        op_fault <= 1'b0;
        idle(6);
        chk(irq, 1'b1);
        rd_t(fpc_pkg::IRQ_STAT_OFS, flt ? 32'h00000002 : 32'h00000001);
        idle(3);
        chk(irq, 1'b0);
    endtask
    initial begin
        #20000;
        fails++;
        close_out();
    end
    initial begin
        {nrst, wr, rd, op_done, op_fault} = '0;
        addr = 16'h0000;
        wdata = 32'h00000000;
        fails = 0;
        num_checks = 0;
        void'($urandom(32'hf4e5));
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++) rd_t(fpc_pkg::CTRL_OFS + 16'(i * 16), 32'h00000000);
        wr_t(fpc_pkg::KEY_OFS, 32'hffffffff);
        rd_t(fpc_pkg::KEY_OFS, 32'h00000000);
        ecmd.data = $urandom();
        ecmd.src = $urandom();
        wr_t(fpc_pkg::DATA_OFS, ecmd.data);
        wr_t(fpc_pkg::SRC_OFS, ecmd.src);
        rd_t(fpc_pkg::DATA_OFS, ecmd.data);
        rd_t(fpc_pkg::SRC_OFS, ecmd.src);
        wr_t(fpc_pkg::ADDR_OFS, 32'hf0f000ff);
        rd_t(fpc_pkg::ADDR_OFS, 32'hf0f000ff);
        wr_t(fpc_pkg::ADDR_OFS + 16'h0004, 32'h0000000f);
        rd_t(fpc_pkg::ADDR_OFS, 32'hf0f000f0);
        wr_t(fpc_pkg::ADDR_OFS + 16'h0008, 32'h0f000000);
        rd_t(fpc_pkg::ADDR_OFS, 32'hfff000f0);
        wr_t(fpc_pkg::ADDR_OFS + 16'h000c, 32'hffffffff);
        rd_t(fpc_pkg::ADDR_OFS, 32'h000fff0f);
        wr_t(fpc_pkg::CTRL_OFS, 32'hffff0fe5);
        rd_t(fpc_pkg::CTRL_OFS, 32'h00000005);
        wr_t(fpc_pkg::CTRL_OFS + 16'h0008, 32'h00000002);
        rd_t(fpc_pkg::CTRL_OFS, 32'h00000007);
        wr_t(fpc_pkg::CTRL_OFS + 16'h000c, 32'h00000003);
        rd_t(fpc_pkg::CTRL_OFS, 32'h00000004);
        wr_t(fpc_pkg::CTRL_OFS + 16'h0004, 32'h00000004);
        rd_t(fpc_pkg::CTRL_OFS, 32'h00000000);
        wr_t(fpc_pkg::IRQ_MASK_OFS, 32'hffffffff);
        rd_t(fpc_pkg::IRQ_MASK_OFS, fpc_pkg::IRQ_BITS);
        for (int i = 0; i < 4; i++) run_op(OPS[i], 1'b0);
        run_op(fpc_pkg::OP_PAGE, 1'b1);
        wr_t(fpc_pkg::KEY_OFS, fpc_pkg::KEY_FIRST);
        rd_t(fpc_pkg::KEY_OFS, 32'h00000000);
        wr_t(fpc_pkg::KEY_OFS, fpc_pkg::KEY_SECOND);
        wr_t(fpc_pkg::CTRL_OFS, 32'h0000c001);
        idle(8);
        chk(cmd_q.size(), 0);
        close_out();
    end
endmodule
